/* hdl/illum_mode_pulse_timing.sv */
// Function
// R1: blue output low at its off count
// R2: infrared one high at its on count
// R3: infrared one low at its off count
// R4: infrared one bit four selects shift combining
// R5: infrared two bit four selects shift combining
// R6: infrared two high at its on count
// R7: infrared two low at its off count
// R8: page register at last address selects page
// R9: mode output high at its on count
// R10: mode output low at its off count
// R11: software keeps unused upper bits zero
// R12: each infrared output has enable bit
// R13: counter restarts per line, outputs hold
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module illum_mode_pulse_timing
  import illum_timing_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  input  wire logic              line_start_i,
  input  wire logic              pixel_en_i,
  input  wire logic              shift_pulse_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  output logic                   blue_illum_out_o,
  output logic                   infrared1_illum_out_o,
  output logic                   infrared2_illum_out_o,
  output logic                   sensor_mode_o
);

  localparam logic [P3_N-1:0][7:0] P3_RESET = {
    RST_IR2_OFF_LOWER, RST_IR2_OFF_UPPER,
    RST_IR2_ON_LOWER,  RST_IR2_ON_UPPER,
    RST_IR1_OFF_LOWER, RST_IR1_OFF_UPPER,
    RST_IR1_ON_LOWER,  RST_IR1_ON_UPPER,
    RST_BLUE_OFF_LOWER, RST_BLUE_OFF_UPPER,
    RST_BLUE_ON_LOWER,  RST_BLUE_ON_UPPER
  };

  localparam logic [P4_N-1:0][7:0] P4_RESET = {
    RST_MODE_OFF_LOWER, RST_MODE_OFF_UPPER,
    RST_MODE_ON_LOWER,  RST_MODE_ON_UPPER
  };

  typedef struct packed {
    logic [7:0]              page;
    logic [P3_N-1:0][7:0]    p3;
    logic [P4_N-1:0][7:0]    p4;
    logic [7:0]              illum_enable;
    logic [DATA_W-1:0]       rdata;
    logic                    blue;
    logic                    ir1;
    logic                    ir2;
    logic                    mode;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  bus_req_t         bus;
  logic [PIX_W-1:0] pix_count;
  chan_cfg_t        blue_cfg;
  chan_cfg_t        ir1_cfg;
  chan_cfg_t        ir2_cfg;
  chan_cfg_t        mode_cfg;
  logic             blue_pulse;
  logic             ir1_pulse;
  logic             ir2_pulse;
  logic             mode_pulse;

  // joins an upper nibble and a lower byte into a pixel count
  function automatic logic [PIX_W-1:0] join_count(
    input logic [7:0] upper,
    input logic [7:0] lower
  );
    join_count = {upper[UPPER_NIBBLE_MSB:0], lower};
  endfunction

  // page 3 array index from a register offset
  function automatic logic [3:0] p3_index(input logic [4:0] off);
    p3_index = 4'(off - OFF_BLUE_ON_UPPER);
  endfunction

  function automatic logic in_p3(input logic [4:0] off);
    in_p3 = (off >= OFF_BLUE_ON_UPPER) && (off <= OFF_IR2_OFF_LOWER);
  endfunction

  function automatic logic in_p4(input logic [4:0] off);
    in_p4 = (off <= OFF_MODE_OFF_LOWER);
  endfunction

  // page 4 array index from a register offset
  function automatic logic [1:0] p4_index(input logic [4:0] off);
    p4_index = off[1:0];
  endfunction

  // the page register answers on every page
  function automatic logic is_page_sel(input logic [4:0] off);
    is_page_sel = (off == OFF_PAGE_SELECT);
  endfunction

  // output status byte, upper nibble reads zero
  function automatic logic [7:0] out_status(input top_state_t st);
    out_status = {4'h0, st.mode, st.ir2, st.ir1, st.blue};
  endfunction

  // pixel count readback, upper byte holds the top nibble
  function automatic logic [7:0] count_byte(
    input logic [PIX_W-1:0] count,
    input logic             upper
  );
    count_byte = upper ? 8'({4'h0, count[PIX_W-1:8]}) : count[7:0];
  endfunction

  assign bus.addr  = reg_addr_i;
  assign bus.wdata = reg_wdata_i;
  assign bus.wr    = reg_wr_i;
  assign bus.rd    = reg_rd_i;

  // channel configuration from the register file
  always_comb
  begin
    blue_cfg.on_count  = join_count(
      s_q.p3[p3_index(OFF_BLUE_ON_UPPER)],
      s_q.p3[p3_index(OFF_BLUE_ON_LOWER)]);
    blue_cfg.off_count = join_count(
      s_q.p3[p3_index(OFF_BLUE_OFF_UPPER)],
      s_q.p3[p3_index(OFF_BLUE_OFF_LOWER)]); // [R1]
    blue_cfg.combine   =
      s_q.p3[p3_index(OFF_BLUE_ON_UPPER)][COMBINE_BIT];
    blue_cfg.enable    = 1'b1;

    ir1_cfg.on_count   = join_count(
      s_q.p3[p3_index(OFF_IR1_ON_UPPER)],
      s_q.p3[p3_index(OFF_IR1_ON_LOWER)]); // [R2]
    ir1_cfg.off_count  = join_count(
      s_q.p3[p3_index(OFF_IR1_OFF_UPPER)],
      s_q.p3[p3_index(OFF_IR1_OFF_LOWER)]); // [R3]
    ir1_cfg.combine    =
      s_q.p3[p3_index(OFF_IR1_ON_UPPER)][COMBINE_BIT]; // [R4]
    ir1_cfg.enable     = s_q.illum_enable[IR1_ENABLE_BIT]; // [R12]

    ir2_cfg.on_count   = join_count(
      s_q.p3[p3_index(OFF_IR2_ON_UPPER)],
      s_q.p3[p3_index(OFF_IR2_ON_LOWER)]); // [R6]
    ir2_cfg.off_count  = join_count(
      s_q.p3[p3_index(OFF_IR2_OFF_UPPER)],
      s_q.p3[p3_index(OFF_IR2_OFF_LOWER)]); // [R7]
    ir2_cfg.combine    =
      s_q.p3[p3_index(OFF_IR2_ON_UPPER)][COMBINE_BIT]; // [R5]
    ir2_cfg.enable     = s_q.illum_enable[IR2_ENABLE_BIT]; // [R12]

    mode_cfg.on_count  = join_count(
      s_q.p4[p4_index(OFF_MODE_ON_UPPER)],
      s_q.p4[p4_index(OFF_MODE_ON_LOWER)]); // [R9]
    mode_cfg.off_count = join_count(
      s_q.p4[p4_index(OFF_MODE_OFF_UPPER)],
      s_q.p4[p4_index(OFF_MODE_OFF_LOWER)]); // [R10]
    mode_cfg.combine   = 1'b0;
    mode_cfg.enable    = 1'b1;
  end

  pixel_counter #(
    .WIDTH (PIX_W)
  ) u_pixel_counter (
    .sys_clk_i    (sys_clk_i),
    .srst_i       (srst_i),
    .line_start_i (line_start_i),
    .pixel_en_i   (pixel_en_i),
    .count_o      (pix_count)
  );

  pulse_channel u_blue (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .count_i       (pix_count),
    .cfg_i         (blue_cfg),
    .shift_pulse_i (shift_pulse_i),
    .pulse_o       (blue_pulse)
  );

  pulse_channel u_ir1 (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .count_i       (pix_count),
    .cfg_i         (ir1_cfg),
    .shift_pulse_i (shift_pulse_i),
    .pulse_o       (ir1_pulse)
  );

  pulse_channel u_ir2 (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .count_i       (pix_count),
    .cfg_i         (ir2_cfg),
    .shift_pulse_i (shift_pulse_i),
    .pulse_o       (ir2_pulse)
  );

  pulse_channel u_mode (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .count_i       (pix_count),
    .cfg_i         (mode_cfg),
    .shift_pulse_i (shift_pulse_i),
    .pulse_o       (mode_pulse)
  );

  // register writes, read data and output flops
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = '0;

    if (bus.wr)
    begin
      if (is_page_sel(bus.addr))
      begin
        s_d.page = bus.wdata; // [R8]
      end
      else
      begin
        case (s_q.page)
          PAGE_LAMP:
          begin
            if (in_p3(bus.addr))
            begin
              s_d.p3[p3_index(bus.addr)] = bus.wdata;
            end
          end
          PAGE_MODE:
          begin
            if (in_p4(bus.addr))
            begin
              s_d.p4[p4_index(bus.addr)] = bus.wdata;
            end
          end
          PAGE_CTRL:
          begin
            if (bus.addr == OFF_ILLUM_ENABLE)
            begin
              s_d.illum_enable = bus.wdata;
            end
          end
          default:
          begin
            s_d.page = s_q.page;
          end
        endcase
      end
    end

    if (bus.rd)
    begin
      if (is_page_sel(bus.addr))
      begin
        s_d.rdata = s_q.page; // [R8]
      end
      else
      begin
        case (s_q.page)
          PAGE_LAMP:
          begin
            if (in_p3(bus.addr))
            begin
              s_d.rdata = s_q.p3[p3_index(bus.addr)];
            end
          end
          PAGE_MODE:
          begin
            if (in_p4(bus.addr))
            begin
              s_d.rdata = s_q.p4[p4_index(bus.addr)];
            end
          end
          PAGE_CTRL:
          begin
            case (bus.addr)
              OFF_ILLUM_ENABLE:
              begin
                s_d.rdata = s_q.illum_enable;
              end
              OFF_OUT_STATUS:
              begin
                s_d.rdata = out_status(s_q);
              end
              OFF_COUNT_UPPER:
              begin
                s_d.rdata = count_byte(pix_count, 1'b1);
              end
              OFF_COUNT_LOWER:
              begin
                s_d.rdata = count_byte(pix_count, 1'b0);
              end
              default:
              begin
                s_d.rdata = '0;
              end
            endcase
          end
          default:
          begin
            s_d.rdata = '0;
          end
        endcase
      end
    end

    s_d.blue = blue_pulse;
    s_d.ir1  = ir1_pulse;
    s_d.ir2  = ir2_pulse;
    s_d.mode = mode_pulse;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      s_q.page         <= RST_PAGE_SELECT; // [R8]
      s_q.p3           <= P3_RESET;
      s_q.p4           <= P4_RESET;
      s_q.illum_enable <= RST_ILLUM_ENABLE;
      s_q.rdata        <= '0;
      s_q.blue         <= 1'b0;
      s_q.ir1          <= 1'b0;
      s_q.ir2          <= 1'b0;
      s_q.mode         <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o           = s_q.rdata;
  assign blue_illum_out_o      = s_q.blue;
  assign infrared1_illum_out_o = s_q.ir1;
  assign infrared2_illum_out_o = s_q.ir2;
  assign sensor_mode_o         = s_q.mode;

endmodule
`default_nettype wire

/* hdl/illum_timing_pkg.sv */
package illum_timing_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIX_W  = 12;

  // page numbers
  localparam logic [7:0] PAGE_LAMP = 8'h03;
  localparam logic [7:0] PAGE_MODE = 8'h04;
  localparam logic [7:0] PAGE_CTRL = 8'h05;

  // page 3 offsets
  localparam logic [4:0] OFF_BLUE_ON_UPPER  = 5'h13;
  localparam logic [4:0] OFF_BLUE_ON_LOWER  = 5'h14;
  localparam logic [4:0] OFF_BLUE_OFF_UPPER = 5'h15;
  localparam logic [4:0] OFF_BLUE_OFF_LOWER = 5'h16;
  localparam logic [4:0] OFF_IR1_ON_UPPER   = 5'h17;
  localparam logic [4:0] OFF_IR1_ON_LOWER   = 5'h18;
  localparam logic [4:0] OFF_IR1_OFF_UPPER  = 5'h19;
  localparam logic [4:0] OFF_IR1_OFF_LOWER  = 5'h1a;
  localparam logic [4:0] OFF_IR2_ON_UPPER   = 5'h1b;
  localparam logic [4:0] OFF_IR2_ON_LOWER   = 5'h1c;
  localparam logic [4:0] OFF_IR2_OFF_UPPER  = 5'h1d;
  localparam logic [4:0] OFF_IR2_OFF_LOWER  = 5'h1e;
  localparam logic [4:0] OFF_PAGE_SELECT    = 5'h1f;
  localparam int unsigned P3_N = 12;

  // page 4 offsets
  localparam logic [4:0] OFF_MODE_ON_UPPER  = 5'h00;
  localparam logic [4:0] OFF_MODE_ON_LOWER  = 5'h01;
  localparam logic [4:0] OFF_MODE_OFF_UPPER = 5'h02;
  localparam logic [4:0] OFF_MODE_OFF_LOWER = 5'h03;
  localparam int unsigned P4_N = 4;

  // page 5 offsets
  localparam logic [4:0] OFF_ILLUM_ENABLE = 5'h00;
  localparam logic [4:0] OFF_OUT_STATUS   = 5'h01;
  localparam logic [4:0] OFF_COUNT_UPPER  = 5'h02;
  localparam logic [4:0] OFF_COUNT_LOWER  = 5'h03;

  // reset values
  localparam logic [7:0] RST_BLUE_ON_UPPER  = 8'h00;
  localparam logic [7:0] RST_BLUE_ON_LOWER  = 8'h13;
  localparam logic [7:0] RST_BLUE_OFF_UPPER = 8'h03;
  localparam logic [7:0] RST_BLUE_OFF_LOWER = 8'h30;
  localparam logic [7:0] RST_IR1_ON_UPPER   = 8'h00;
  localparam logic [7:0] RST_IR1_ON_LOWER   = 8'h14;
  localparam logic [7:0] RST_IR1_OFF_UPPER  = 8'h03;
  localparam logic [7:0] RST_IR1_OFF_LOWER  = 8'h30;
  localparam logic [7:0] RST_IR2_ON_UPPER   = 8'h00;
  localparam logic [7:0] RST_IR2_ON_LOWER   = 8'h15;
  localparam logic [7:0] RST_IR2_OFF_UPPER  = 8'h03;
  localparam logic [7:0] RST_IR2_OFF_LOWER  = 8'h30;
  localparam logic [7:0] RST_PAGE_SELECT    = 8'h00;
  localparam logic [7:0] RST_MODE_ON_UPPER  = 8'h02;
  localparam logic [7:0] RST_MODE_ON_LOWER  = 8'h00;
  localparam logic [7:0] RST_MODE_OFF_UPPER = 8'h03;
  localparam logic [7:0] RST_MODE_OFF_LOWER = 8'h01;
  localparam logic [7:0] RST_ILLUM_ENABLE   = 8'h00;

  // field positions
  localparam int unsigned UPPER_NIBBLE_MSB = 3;
  localparam int unsigned COMBINE_BIT      = 4;
  localparam int unsigned IR1_ENABLE_BIT   = 0;
  localparam int unsigned IR2_ENABLE_BIT   = 1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic [PIX_W-1:0] on_count;
    logic [PIX_W-1:0] off_count;
    logic             combine;
    logic             enable;
  } chan_cfg_t;

endpackage

/* hdl/pixel_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module pixel_counter
  import illum_timing_pkg::*;
#(
  parameter int unsigned WIDTH = PIX_W
)(
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             line_start_i,
  input  wire logic             pixel_en_i,
  output logic      [WIDTH-1:0] count_o
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (line_start_i)
    begin
      s_d.count = '0; // [R13]
    end
    else if (pixel_en_i)
    begin
      s_d.count = s_q.count + WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.count;

endmodule
`default_nettype wire

/* hdl/pulse_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_channel
  import illum_timing_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [PIX_W-1:0] count_i,
  input  wire chan_cfg_t        cfg_i,
  input  wire logic             shift_pulse_i,
  output logic                  pulse_o
);

  typedef struct packed {
    logic level;
  } chan_state_t;

  chan_state_t s_q;
  chan_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (!cfg_i.enable)
    begin
      s_d.level = 1'b0; // [R12]
    end
    else if (count_i == cfg_i.off_count)
    begin
      // off wins when both compare values are equal
      s_d.level = 1'b0; // [R1] [R3] [R7] [R10]
    end
    else if (count_i == cfg_i.on_count)
    begin
      s_d.level = 1'b1; // [R2] [R6] [R9]
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d; // [R13]
    end
  end

  // shift pulse or-ed in when combining is selected
  assign pulse_o = cfg_i.enable
                   & (s_q.level | (cfg_i.combine & shift_pulse_i)); // [R4] [R5]

endmodule
`default_nettype wire

/* tb/illum_timing_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module illum_timing_assertions
  import illum_timing_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  input  wire logic              line_start_i,
  input  wire logic              pixel_en_i,
  input  wire logic              shift_pulse_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [DATA_W-1:0] reg_rdata_o,
  input  wire logic              blue_illum_out_o,
  input  wire logic              infrared1_illum_out_o,
  input  wire logic              infrared2_illum_out_o,
  input  wire logic              sensor_mode_o
);
  logic [7:0]       page_q;
  logic [1:0]       en_q;
  logic [1:0]       comb_q;
  logic [PIX_W-1:0] cnt_q;
  logic [PIX_W-1:0] on_q;
  logic [PIX_W-1:0] off_q;
  logic             wr3;
  assign wr3 = reg_wr_i && page_q == PAGE_LAMP;
  // shadow of page, enables, infrared one counts and pixel count
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      page_q <= 8'h00;
      en_q   <= 2'h0;
      comb_q <= 2'h0;
      cnt_q  <= 12'h000;
      on_q   <= 12'h014;
      off_q  <= 12'h330;
    end
    else
    begin
      cnt_q <= line_start_i ? 12'h000 : cnt_q + {11'h000, pixel_en_i};
      if (reg_wr_i && reg_addr_i == OFF_PAGE_SELECT)
        page_q <= reg_wdata_i;
      if (reg_wr_i && page_q == PAGE_CTRL && reg_addr_i == OFF_ILLUM_ENABLE)
        en_q <= reg_wdata_i[1:0];
      if (wr3 && reg_addr_i == OFF_IR1_ON_UPPER)
        {comb_q[0], on_q[11:8]} <= reg_wdata_i[4:0];
      if (wr3 && reg_addr_i == OFF_IR1_ON_LOWER)
        on_q[7:0] <= reg_wdata_i;
      if (wr3 && reg_addr_i == OFF_IR1_OFF_UPPER)
        off_q[11:8] <= reg_wdata_i[3:0];
      if (wr3 && reg_addr_i == OFF_IR1_OFF_LOWER)
        off_q[7:0] <= reg_wdata_i;
      if (wr3 && reg_addr_i == OFF_IR2_ON_UPPER)
        comb_q[1] <= reg_wdata_i[4];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read answer");
  page_readback_a: assert property ($past(reg_rd_i && reg_addr_i == 5'h1f)
    |-> reg_rdata_o == $past(page_q)) else $error("page readback wrong");
  reset_quiet_a: assert property ($past(srst_i) |-> !(blue_illum_out_o ||
    infrared1_illum_out_o || infrared2_illum_out_o || sensor_mode_o))
    else $error("output high after reset");
  ir1_masked_a: assert property (!en_q[0] && !$past(en_q[0])
    |-> !infrared1_illum_out_o) else $error("disabled ir1 high");
  ir2_masked_a: assert property (!en_q[1] && !$past(en_q[1])
    |-> !infrared2_illum_out_o) else $error("disabled ir2 high");
  ir1_rise_a: assert property (en_q[0] && cnt_q == on_q && on_q != off_q
    |-> ##2 infrared1_illum_out_o) else $error("ir1 did not rise");
  ir1_fall_a: assert property (en_q[0] && !comb_q[0] && cnt_q == off_q
    |-> ##2 !infrared1_illum_out_o) else $error("ir1 did not fall");
  ir1_combine_a: assert property (en_q[0] && comb_q[0] && shift_pulse_i
    |=> infrared1_illum_out_o) else $error("ir1 shift not combined");
  ir2_combine_a: assert property (en_q[1] && comb_q[1] && shift_pulse_i
    |=> infrared2_illum_out_o) else $error("ir2 shift not combined");
endmodule
bind illum_mode_pulse_timing illum_timing_assertions chk (.*);
`default_nettype wire

/* tb/lamp_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module lamp_sink (
  input  wire logic       sys_clk_i,
  input  wire logic [3:0] lamp_i,
  output logic      [3:0] change_o
);
  logic [3:0] prev_q;
  // lamps and mode input only see levels; report each level change
  always_ff @(posedge sys_clk_i)
  begin
    prev_q <= lamp_i;
  end
  assign change_o = lamp_i ^ prev_q;
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import illum_timing_pkg::*;
;
  logic              sys_clk_i = 1'b0;
  logic              srst_i = 1'b1;
  logic              line_start_i = 1'b0;
  logic              pixel_en_i = 1'b0;
  logic              shift_pulse_i = 1'b0;
  bus_req_t          req = '0;
  logic [DATA_W-1:0] rdata;
  logic [3:0]        lamp;
  logic [3:0]        chg;
  logic              rd_pend = 1'b0;
  logic              watch = 1'b1;
  logic [11:0]       since = 12'h000;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                cyc = 0;
  logic [7:0]        rd_q[$];
  logic [11:0]       edge_q[4][$];
  logic [11:0]       on_v[4];
  logic [11:0]       off_v[4];
  logic [4:0]        on_a[4] = '{5'h13, 5'h17, 5'h1b, 5'h00};
  logic [7:0]        p3_def[11] = '{8'h03, 8'h30, 8'h00, 8'h14, 8'h03,
                                    8'h30, 8'h00, 8'h15, 8'h03, 8'h30, 8'h03};
  logic [7:0]        p4_def[3] = '{8'h02, 8'h00, 8'h03};
  illum_mode_pulse_timing DUT (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .line_start_i(line_start_i),
    .pixel_en_i(pixel_en_i), .shift_pulse_i(shift_pulse_i),
    .reg_addr_i(req.addr), .reg_wdata_i(req.wdata), .reg_wr_i(req.wr),
    .reg_rd_i(req.rd), .reg_rdata_o(rdata), .blue_illum_out_o(lamp[0]),
    .infrared1_illum_out_o(lamp[1]), .infrared2_illum_out_o(lamp[2]),
    .sensor_mode_o(lamp[3]));
  lamp_sink far_side (.sys_clk_i(sys_clk_i), .lamp_i(lamp), .change_o(chg));
  always #5 sys_clk_i = ~sys_clk_i;
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: d, wr: w, rd: ~w};
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic set12(input logic [4:0] a, input logic [11:0] v);
    // lower byte first so no half-written count passes through zero
    wr(5'(a + 5'h01), v[7:0]);
    wr(a, {4'h0, v[11:8]});
  endtask
  task automatic line(input int n);
    @(posedge sys_clk_i);
    req <= '0;
    line_start_i <= 1'b1;
    @(posedge sys_clk_i);
    line_start_i <= 1'b0;
    pixel_en_i <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    pixel_en_i <= 1'b0;
  endtask
  always @(posedge sys_clk_i)
  begin
    rd_pend <= req.rd;
    since <= line_start_i ? 12'h000 : since + 12'h001;
    shift_pulse_i <= 1'($urandom % 2);
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  // compare answers against the oldest note
  always @(negedge sys_clk_i)
  begin
    if (rd_pend === 1'b1)
      check({4'h0, rdata}, {4'h0, rd_q.pop_front()});
    for (int k = 0; k < 4; k++)
      if (watch && chg[k] === 1'b1)
        check(since, edge_q[k].size() > 0 ? edge_q[k].pop_front() : 12'hfff);
  end
  initial
  begin
    logic [7:0] v;
    void'($urandom(10752));
    repeat (8) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    wr(OFF_PAGE_SELECT, PAGE_LAMP);
    rd(OFF_PAGE_SELECT, PAGE_LAMP);
    for (int i = 0; i < 11; i++)
      rd(5'(5'h15 + i), p3_def[i]);
    rd(5'h00, 8'h00);
    wr(OFF_PAGE_SELECT, PAGE_MODE);
    for (int i = 0; i < 3; i++)
      rd(5'(i), p4_def[i]);
    wr(OFF_PAGE_SELECT, 8'h06);
    rd(5'h00, 8'h00);
    rd(OFF_PAGE_SELECT, 8'h06);
    wr(OFF_PAGE_SELECT, PAGE_LAMP);
    for (int i = 0; i < 10; i++)
    begin
      v = 8'($urandom);
      if (i % 2 == 0)
        v = v & 8'h0f;
      wr(5'(5'h15 + i), v);
      rd(5'(5'h15 + i), v);
    end
    for (int k = 0; k < 4; k++)
    begin
      if (k == 3)
        wr(OFF_PAGE_SELECT, PAGE_MODE);
      on_v[k] = 12'(8 + $urandom % 60);
      off_v[k] = on_v[k] + 12'(30 + $urandom % 60);
      set12(on_a[k], on_v[k]);
      set12(5'(on_a[k] + 5'h02), off_v[k]);
    end
    wr(OFF_PAGE_SELECT, PAGE_CTRL);
    wr(OFF_ILLUM_ENABLE, 8'h03);
    for (int k = 0; k < 4; k++)
    begin
      edge_q[k].push_back(on_v[k] + 12'd2);
      edge_q[k].push_back(off_v[k] + 12'd2);
    end
    line(300);
    rd(OFF_COUNT_UPPER, 8'h01);
    rd(OFF_COUNT_LOWER, 8'h2c);
    rd(OFF_OUT_STATUS, 8'h00);
    wr(OFF_ILLUM_ENABLE, 8'h00);
    for (int k = 0; k < 4; k += 3)
    begin
      edge_q[k].push_back(on_v[k] + 12'd2);
      edge_q[k].push_back(off_v[k] + 12'd2);
    end
    line(300);
    watch <= 1'b0;
    wr(OFF_PAGE_SELECT, PAGE_LAMP);
    wr(OFF_IR1_ON_UPPER, {4'h1, on_v[1][11:8]});
    wr(OFF_IR2_ON_UPPER, {4'h1, on_v[2][11:8]});
    wr(OFF_PAGE_SELECT, PAGE_CTRL);
    wr(OFF_ILLUM_ENABLE, 8'h03);
    line(1);
    repeat (60) @(posedge sys_clk_i);
    check(12'(edge_q[0].size() + edge_q[1].size() + edge_q[2].size()
          + edge_q[3].size()), 12'h000);
    wrap_up();
  end
endmodule
`default_nettype wire
